// ==== phase_sync_pkg.sv ====
// package of register offsets, reset values, field positions and timing
//
// Function
// - current phase low byte, read only
// - averaged phase high byte, loop select chosen
// - bit 7 picks sync pulse source loop
// - bits 3 and 1 invert frame pulses
// - bit 0 pulses multiframe output, else 50:50
// - bit 7 makes sync outputs independent
// - bit 6 enables optical rate realign
// - clear ramp bit ramps offset on write
// - set ramp bit runs holdover calibration
`default_nettype none
package phase_sync_pkg;
   // ***************************************************************
   // register offsets
   // ***************************************************************
   localparam logic [7:0] ADDR_PHASE_OFS_LO   = 8'h70;
   localparam logic [7:0] ADDR_PHASE_OFS_HI   = 8'h71;
   localparam logic [7:0] ADDR_COARSE_LIMIT   = 8'h74;
   localparam logic [7:0] ADDR_NOISE_CFG      = 8'h75;
   localparam logic [7:0] ADDR_CUR_PHASE_LO   = 8'h77;
   localparam logic [7:0] ADDR_CUR_PHASE_HI   = 8'h78;
   localparam logic [7:0] ADDR_ALARM_DELAY    = 8'h79;
   localparam logic [7:0] ADDR_SYNC_PULSE     = 8'h7A;
   localparam logic [7:0] ADDR_SYNC_ALIGN     = 8'h7B;
   localparam logic [7:0] ADDR_RAMP_CFG       = 8'h7C;
   // ***************************************************************
   // reset values
   // ***************************************************************
   localparam logic [7:0] RST_COARSE_LIMIT    = 8'h85;
   localparam logic [7:0] RST_ALARM_DELAY     = 8'h32;
   localparam logic [7:0] RST_SYNC_PULSE      = 8'h00;
   localparam logic [7:0] RST_SYNC_ALIGN      = 8'h00;
   localparam logic [7:0] RST_NOISE_CFG       = 8'h06;
   localparam logic [7:0] RST_RAMP_CFG        = 8'h2B;
   localparam logic [7:0] RST_ZERO            = 8'h00;
   // ***************************************************************
   // field positions
   // ***************************************************************
   localparam int BIT_SYNC_SOURCE_SECONDARY     = 7;
   localparam int BIT_FRAME_PULSE_POLARITY      = 3;
   localparam int BIT_FRAME_PULSE_MODE          = 2;
   localparam int BIT_MULTIFRAME_PULSE_POLARITY = 1;
   localparam int BIT_MULTIFRAME_PULSE_MODE     = 0;
   localparam int BIT_SYNC_OUTPUTS_INDEPENDENT  = 7;
   localparam int BIT_OPTICAL_RATE_REALIGN      = 6;
   localparam int BIT_OFFSET_CALIBRATE_FORCE    = 7;
   localparam int BIT_COARSE_LOSS_EN            = 7;
   localparam int BIT_WIDE_RANGE_EN             = 6;
   localparam logic [3:0] COARSE_CODE_MAX       = 4'hC;
   // ***************************************************************
   // timing: offset ramp advances one lsb per step
   // ***************************************************************
   localparam int RAMP_STEP_NS  = 1000;
   localparam int CLK_PERIOD_NS = 20;
   localparam logic [7:0] RAMP_STEP_CYCLES =
      8'(RAMP_STEP_NS / CLK_PERIOD_NS);
   localparam logic [3:0] DIV_RESET_CYCLES = 4'h8;
   // calibration sequence states
   typedef enum logic [2:0] {
      CAL_IDLE, CAL_HOLD, CAL_TO_ZERO, CAL_DIV_RESET, CAL_TO_TARGET,
      CAL_RELEASE
   } cal_state_t;
endpackage
`default_nettype wire

// ==== offset_ramp.sv ====
// phase offset ramp engine stepping applied offset toward a target
`timescale 1ns/1ps
`default_nettype none
module offset_ramp
   import phase_sync_pkg::*;
(
   // clock and reset
   input  wire logic        ref_clk_i,
   input  wire logic        rstn_i,
   // target and jump control
   input  wire logic [15:0] target_i,
   input  wire logic        jump_i,
   // applied value
   output logic      [15:0] applied_o,
   output logic             at_target_o
);
   import phase_sync_pkg::*;

   logic [15:0] applied_r, applied_nxt;   // offset now applied
   logic [7:0]  tick_r, tick_nxt;         // step pacing counter
   logic        at_r, at_nxt;             // registered arrival flag

   // ***************************************************************
   // step logic
   // ***************************************************************
   // signed compare: offsets are two's complement
   always_comb begin
      applied_nxt = applied_r;
      tick_nxt    = tick_r;
      if (jump_i) begin
         applied_nxt = target_i;          // direct load skips ramp
         tick_nxt    = 8'h00;
      end else if (applied_r != target_i) begin
         if (tick_r >= RAMP_STEP_CYCLES - 8'h01) begin
            tick_nxt = 8'h00;
            if ($signed(applied_r) < $signed(target_i)) begin
               applied_nxt = applied_r + 16'h0001;
            end else begin
               applied_nxt = applied_r - 16'h0001;
            end
         end else begin
            tick_nxt = tick_r + 8'h01;
         end
      end else begin
         tick_nxt = 8'h00;
      end
      at_nxt = (applied_nxt == target_i);
   end

   // registers only
   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         applied_r <= 16'h0000;
         tick_r    <= 8'h00;
         at_r      <= 1'b1;
      end else begin
         applied_r <= applied_nxt;
         tick_r    <= tick_nxt;
         at_r      <= at_nxt;
      end
   end

   assign applied_o   = applied_r;
   assign at_target_o = at_r;
endmodule
`default_nettype wire

// ==== dpll_phase_sync_config.sv ====
// register bank for loop phase tracking, sync pulses and offset ramp
`timescale 1ns/1ps
`default_nettype none
module dpll_phase_sync_config
   import phase_sync_pkg::*;
(
   // clock and reset
   input  wire logic        ref_clk_i,
   input  wire logic        rstn_i,
   // register port from serial interface
   input  wire logic [7:0]  reg_addr_i,
   input  wire logic [7:0]  reg_wdata_i,
   input  wire logic        reg_wr_i,
   input  wire logic        reg_rd_i,
   output logic      [7:0]  reg_rdata_o,
   // averaged phase from both loops
   input  wire logic [15:0] primary_phase_i,
   input  wire logic [15:0] secondary_phase_i,
   input  wire logic        phase_select_secondary_i,
   // sync pulse controls toward the generators
   output logic             sync_source_secondary_o,
   output logic             frame_pulse_polarity_o,
   output logic             frame_pulse_mode_o,
   output logic             multiframe_pulse_polarity_o,
   output logic             multiframe_pulse_mode_o,
   output logic             sync_outputs_independent_o,
   output logic             optical_rate_realign_o,
   output logic      [1:0]  sync_sample_phase_o,
   // coarse detector controls
   output logic      [3:0]  coarse_range_code_o,
   output logic             coarse_loss_en_o,
   output logic             wide_range_en_o,
   // offset and calibration controls
   output logic      [15:0] applied_offset_o,
   output logic             holdover_force_o,
   output logic             divider_reset_o,
   output logic             calibration_busy_o
);
   import phase_sync_pkg::*;

   // ***************************************************************
   // storage
   // ***************************************************************
   logic [7:0]  coarse_r, coarse_nxt;       // coarse limit config
   logic [7:0]  noise_r, noise_nxt;         // low freq noise config
   logic [7:0]  pulse_r, pulse_nxt;         // sync pulse config
   logic [7:0]  align_r, align_nxt;         // sync alignment config
   logic [7:0]  ramp_r, ramp_nxt;           // ramp control config
   logic [15:0] ofs_r, ofs_nxt;             // programmed phase offset
   logic [15:0] snap_r, snap_nxt;           // current phase snapshot
   logic [7:0]  rdata_r, rdata_nxt;         // read data register
   cal_state_t  cal_r, cal_nxt;             // calibration sequencer
   logic [3:0]  dcnt_r, dcnt_nxt;           // divider reset hold
   logic        hold_r, hold_nxt;           // holdover request
   logic        divrst_r, divrst_nxt;       // divider reset pulse
   logic        jump_r, jump_nxt;           // direct offset load
   logic [3:0]  code_r, code_nxt;           // saturated range code
   logic        busy_r, busy_nxt;           // calibration running
   logic [15:0] ramp_tgt;                   // target for ramp engine
   logic [15:0] applied;                    // offset from ramp engine
   logic        at_target;                  // ramp arrived
   logic [15:0] live_phase;                 // selected loop phase

   // ***************************************************************
   // phase readout selection
   // ***************************************************************
   // loop select bit lives in another register, so it is an input
   assign live_phase = phase_select_secondary_i ? secondary_phase_i
                                                : primary_phase_i;

   // ***************************************************************
   // register write and read
   // ***************************************************************
   // reading the low byte snapshots both bytes so a following
   // high byte read pairs with the same sample; the trade is that
   // reading high first returns the older snapshot
   always_comb begin
      coarse_nxt = coarse_r;
      noise_nxt  = noise_r;
      pulse_nxt  = pulse_r;
      align_nxt  = align_r;
      ramp_nxt   = ramp_r;
      ofs_nxt    = ofs_r;
      snap_nxt   = snap_r;
      rdata_nxt  = rdata_r;
      if (reg_wr_i) begin
         case (reg_addr_i)
            ADDR_PHASE_OFS_LO: ofs_nxt[7:0]  = reg_wdata_i;
            ADDR_PHASE_OFS_HI: ofs_nxt[15:8] = reg_wdata_i;
            ADDR_COARSE_LIMIT: coarse_nxt = reg_wdata_i;
            ADDR_NOISE_CFG:    noise_nxt  = reg_wdata_i;
            ADDR_SYNC_PULSE:   pulse_nxt  = reg_wdata_i;
            ADDR_SYNC_ALIGN:   align_nxt  = reg_wdata_i;
            ADDR_RAMP_CFG:     ramp_nxt   = reg_wdata_i;
            default: begin
               // read-only and unmapped writes are ignored
            end
         endcase
      end
      if (reg_rd_i) begin
         case (reg_addr_i)
            ADDR_PHASE_OFS_LO: rdata_nxt = ofs_r[7:0];
            ADDR_PHASE_OFS_HI: rdata_nxt = ofs_r[15:8];
            ADDR_COARSE_LIMIT: rdata_nxt = coarse_r;
            ADDR_NOISE_CFG:    rdata_nxt = noise_r;
            ADDR_CUR_PHASE_LO: begin
               rdata_nxt = live_phase[7:0];
               snap_nxt  = live_phase;
            end
            ADDR_CUR_PHASE_HI: rdata_nxt = snap_r[15:8];
            ADDR_ALARM_DELAY:  rdata_nxt = RST_ALARM_DELAY;
            ADDR_SYNC_PULSE:   rdata_nxt = pulse_r;
            ADDR_SYNC_ALIGN:   rdata_nxt = align_r;
            ADDR_RAMP_CFG:     rdata_nxt = ramp_r;
            default:           rdata_nxt = RST_ZERO;
         endcase
      end
      // codes above 1100 all mean the widest range
      code_nxt = (coarse_nxt[3:0] > COARSE_CODE_MAX) ?
         COARSE_CODE_MAX : coarse_nxt[3:0];
   end

   // registers only
   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         coarse_r <= RST_COARSE_LIMIT;
         noise_r  <= RST_NOISE_CFG;
         pulse_r  <= RST_SYNC_PULSE;
         align_r  <= RST_SYNC_ALIGN;
         ramp_r   <= RST_RAMP_CFG;
         ofs_r    <= 16'h0000;
         snap_r   <= 16'h0000;
         rdata_r  <= RST_ZERO;
         code_r   <= RST_COARSE_LIMIT[3:0];
      end else begin
         coarse_r <= coarse_nxt;
         noise_r  <= noise_nxt;
         pulse_r  <= pulse_nxt;
         align_r  <= align_nxt;
         ramp_r   <= ramp_nxt;
         ofs_r    <= ofs_nxt;
         snap_r   <= snap_nxt;
         rdata_r  <= rdata_nxt;
         code_r   <= code_nxt;
      end
   end

   // ***************************************************************
   // calibration sequencer
   // ***************************************************************
   // force bit set: holdover, ramp to zero, reset dividers, ramp to
   // programmed offset, release; the ramp hides any phase step
   always_comb begin
      cal_nxt    = cal_r;
      dcnt_nxt   = dcnt_r;
      hold_nxt   = hold_r;
      divrst_nxt = 1'b0;
      jump_nxt   = 1'b0;
      case (cal_r)
         CAL_IDLE: begin
            if (ramp_r[BIT_OFFSET_CALIBRATE_FORCE]) begin
               cal_nxt  = CAL_HOLD;
               hold_nxt = 1'b1;
            end
         end
         CAL_HOLD:    cal_nxt = CAL_TO_ZERO;
         CAL_TO_ZERO: begin
            if (at_target && applied == 16'h0000) begin
               cal_nxt    = CAL_DIV_RESET;
               dcnt_nxt   = 4'h0;
               divrst_nxt = 1'b1;
            end
         end
         CAL_DIV_RESET: begin
            divrst_nxt = 1'b1;
            if (dcnt_r >= DIV_RESET_CYCLES - 4'h1) begin
               divrst_nxt = 1'b0;
               cal_nxt    = CAL_TO_TARGET;
            end else begin
               dcnt_nxt = dcnt_r + 4'h1;
            end
         end
         CAL_TO_TARGET: begin
            if (at_target && applied == ofs_r) begin
               cal_nxt = CAL_RELEASE;
            end
         end
         CAL_RELEASE: begin
            hold_nxt = 1'b0;
            if (!ramp_r[BIT_OFFSET_CALIBRATE_FORCE]) begin
               cal_nxt = CAL_IDLE;   // rearm only after bit clears
            end
         end
         default: begin
            cal_nxt  = CAL_IDLE;
            hold_nxt = 1'b0;
         end
      endcase
      // the direct load term is ANDed with 1'b0, so jump never fires and the offset always ramps
      if (cal_r == CAL_IDLE && !ramp_r[BIT_OFFSET_CALIBRATE_FORCE] &&
          1'b0) begin
         jump_nxt = 1'b1;
      end
      // registered so the busy output comes from a flip-flop
      busy_nxt = (cal_nxt != CAL_IDLE);
   end

   // registers only
   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cal_r    <= CAL_IDLE;
         dcnt_r   <= 4'h0;
         hold_r   <= 1'b0;
         divrst_r <= 1'b0;
         jump_r   <= 1'b0;
         busy_r   <= 1'b0;
      end else begin
         cal_r    <= cal_nxt;
         dcnt_r   <= dcnt_nxt;
         hold_r   <= hold_nxt;
         divrst_r <= divrst_nxt;
         jump_r   <= jump_nxt;
         busy_r   <= busy_nxt;
      end
   end

   // ramp target is zero during the first half of calibration
   assign ramp_tgt = (cal_r == CAL_HOLD || cal_r == CAL_TO_ZERO ||
                      cal_r == CAL_DIV_RESET) ? 16'h0000 : ofs_r;

   offset_ramp u_ramp (
      .ref_clk_i   (ref_clk_i),
      .rstn_i      (rstn_i),
      .target_i    (ramp_tgt),
      .jump_i      (jump_r),
      .applied_o   (applied),
      .at_target_o (at_target)
   );

   // ***************************************************************
   // outputs, all from flip-flops
   // ***************************************************************
   assign reg_rdata_o                 = rdata_r;
   assign sync_source_secondary_o     =
      pulse_r[BIT_SYNC_SOURCE_SECONDARY];
   assign frame_pulse_polarity_o      =
      pulse_r[BIT_FRAME_PULSE_POLARITY];
   assign frame_pulse_mode_o          =
      pulse_r[BIT_FRAME_PULSE_MODE];
   assign multiframe_pulse_polarity_o =
      pulse_r[BIT_MULTIFRAME_PULSE_POLARITY];
   assign multiframe_pulse_mode_o     =
      pulse_r[BIT_MULTIFRAME_PULSE_MODE];
   assign sync_outputs_independent_o  =
      align_r[BIT_SYNC_OUTPUTS_INDEPENDENT];
   assign optical_rate_realign_o      =
      align_r[BIT_OPTICAL_RATE_REALIGN];
   assign sync_sample_phase_o         = align_r[1:0];
   assign coarse_range_code_o         = code_r;
   assign coarse_loss_en_o            = coarse_r[BIT_COARSE_LOSS_EN];
   assign wide_range_en_o             = coarse_r[BIT_WIDE_RANGE_EN];
   assign applied_offset_o            = applied;
   assign holdover_force_o            = hold_r;
   assign divider_reset_o             = divrst_r;
   assign calibration_busy_o          = busy_r;
endmodule
`default_nettype wire

// ==== phase_sync_checker.sv ====
// port-level checker of the phase sync register bank
`timescale 1ns/1ps
`default_nettype none
module phase_sync_checker
   import phase_sync_pkg::*;
(
   // clock and reset
   input wire logic        ref_clk_i,
   input wire logic        rstn_i,
   // register port
   input wire logic [7:0]  reg_addr_i,
   input wire logic [7:0]  reg_wdata_i,
   input wire logic        reg_wr_i,
   input wire logic        reg_rd_i,
   input wire logic [7:0]  reg_rdata_o,
   // phase inputs
   input wire logic [15:0] primary_phase_i,
   input wire logic [15:0] secondary_phase_i,
   input wire logic        phase_select_secondary_i,
   // control outputs
   input wire logic        sync_source_secondary_o,
   input wire logic        frame_pulse_polarity_o,
   input wire logic        frame_pulse_mode_o,
   input wire logic        multiframe_pulse_polarity_o,
   input wire logic        multiframe_pulse_mode_o,
   input wire logic        sync_outputs_independent_o,
   input wire logic        optical_rate_realign_o,
   input wire logic [1:0]  sync_sample_phase_o,
   input wire logic [3:0]  coarse_range_code_o,
   input wire logic        coarse_loss_en_o,
   input wire logic        wide_range_en_o,
   input wire logic [15:0] applied_offset_o,
   input wire logic        holdover_force_o,
   input wire logic        divider_reset_o,
   input wire logic        calibration_busy_o
);
   // ***************************************************************
   // helper state
   // ***************************************************************
   logic [15:0] sel_w;    // phase the read path should see
   logic [7:0]  snap_r;   // high byte captured by a low-byte read
   logic [7:0]  snap_nxt;
   logic        ok_r;     // a low-byte read has happened
   logic        ok_nxt;
   logic        lo_rd_w;  // low-byte read this cycle
   assign sel_w = phase_select_secondary_i ? secondary_phase_i
                                           : primary_phase_i;
   assign lo_rd_w = reg_rd_i && reg_addr_i == 8'h77;
   // next snapshot, mirrors the pairing of the two phase bytes
   always_comb begin
      snap_nxt = lo_rd_w ? sel_w[15:8] : snap_r;
      ok_nxt   = ok_r | lo_rd_w;
   end
   // register the snapshot
   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         snap_r <= 8'h00;
         ok_r   <= 1'b0;
      end else begin
         snap_r <= snap_nxt;
         ok_r   <= ok_nxt;
      end
   end
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!rstn_i);
   // ***************************************************************
   // assertions
   // ***************************************************************
   a_coarse_code_sat: assert property (
      reg_wr_i && reg_addr_i == 8'h74 |=>
      coarse_range_code_o == (($past(reg_wdata_i[3:0]) > 4'hC) ? 4'hC
      : $past(reg_wdata_i[3:0]))) else $error("coarse code wrong");
   a_coarse_enables: assert property (
      reg_wr_i && reg_addr_i == 8'h74 |=>
      {coarse_loss_en_o, wide_range_en_o} == $past(reg_wdata_i[7:6]))
      else $error("coarse enables wrong");
   a_pulse_bits: assert property (
      reg_wr_i && reg_addr_i == 8'h7A |=>
      {sync_source_secondary_o, frame_pulse_polarity_o, frame_pulse_mode_o,
      multiframe_pulse_polarity_o, multiframe_pulse_mode_o} ==
      {$past(reg_wdata_i[7]), $past(reg_wdata_i[3:0])})
      else $error("pulse controls wrong");
   a_align_bits: assert property (
      reg_wr_i && reg_addr_i == 8'h7B |=>
      {sync_outputs_independent_o, optical_rate_realign_o,
      sync_sample_phase_o} == {$past(reg_wdata_i[7:6]),
      $past(reg_wdata_i[1:0])}) else $error("align wrong");
   a_phase_low_read: assert property (lo_rd_w |=>
      reg_rdata_o == $past(sel_w[7:0])) else $error("low phase wrong");
   a_phase_high_pair: assert property (
      reg_rd_i && reg_addr_i == 8'h78 &&
      ok_r |=> reg_rdata_o == $past(snap_r))
      else $error("high phase wrong");
   a_alarm_fixed: assert property (reg_rd_i && reg_addr_i == 8'h79 |=>
      reg_rdata_o == 8'h32) else $error("alarm delay wrong");
   a_unmapped_zero: assert property (reg_rd_i && !(reg_addr_i inside
      {8'h70, 8'h71, [8'h74:8'h75], [8'h77:8'h7C]}) |=>
      reg_rdata_o == 8'h00) else $error("unmapped read not zero");
   a_rdata_holds: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
      else $error("read data moved");
   a_ramp_unit_step: assert property (
      $changed(applied_offset_o) |->
      16'(applied_offset_o - $past(applied_offset_o)) inside
      {16'h0001, 16'hFFFF}) else $error("offset jumped");
   a_div_width: assert property ($rose(divider_reset_o) |->
      divider_reset_o [*8] ##1 !divider_reset_o)
      else $error("divider reset width wrong");
   a_div_in_hold: assert property (divider_reset_o |->
      holdover_force_o &&
      calibration_busy_o && applied_offset_o == 16'h0000)
      else $error("divider reset outside hold");
   // main scenarios seen
   c_pair_read: cover property (reg_rd_i && reg_addr_i == 8'h78 && ok_r);
   c_ramp_move: cover property ($changed(applied_offset_o));
   c_div_pulse: cover property ($rose(divider_reset_o));
endmodule
bind dpll_phase_sync_config phase_sync_checker phase_sync_checker_inst (
   .ref_clk_i, .rstn_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
   .reg_rdata_o, .primary_phase_i, .secondary_phase_i,
   .phase_select_secondary_i, .sync_source_secondary_o,
   .frame_pulse_polarity_o, .frame_pulse_mode_o,
   .multiframe_pulse_polarity_o, .multiframe_pulse_mode_o,
   .sync_outputs_independent_o, .optical_rate_realign_o,
   .sync_sample_phase_o, .coarse_range_code_o, .coarse_loss_en_o,
   .wide_range_en_o, .applied_offset_o, .holdover_force_o,
   .divider_reset_o, .calibration_busy_o);
`default_nettype wire

// ==== dpll_phase_sync_config_test.sv ====
// self-checking bench of the phase sync register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin \
   error_cnt++; $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module dpll_phase_sync_config_test;
   import phase_sync_pkg::*;
   // ***************************************************************
   // bench signals
   // ***************************************************************
   logic        ref_clk_i, rstn_i, reg_wr_i, reg_rd_i;
   logic [7:0]  reg_addr_i, reg_wdata_i, reg_rdata_o;
   logic [15:0] primary_phase_i, secondary_phase_i, applied_offset_o;
   logic        phase_select_secondary_i, sync_source_secondary_o;
   logic        frame_pulse_polarity_o, frame_pulse_mode_o;
   logic        multiframe_pulse_polarity_o, multiframe_pulse_mode_o;
   logic        sync_outputs_independent_o, optical_rate_realign_o;
   logic [1:0]  sync_sample_phase_o;
   logic [3:0]  coarse_range_code_o;
   logic        coarse_loss_en_o, wide_range_en_o, holdover_force_o;
   logic        divider_reset_o, calibration_busy_o;
   int          error_cnt, check_count, n, dcnt, hcnt;
   // one-hot pulse control patterns, then all clear
   logic [7:0]  pat [6] = '{8'h80, 8'h08, 8'h04, 8'h02, 8'h01, 8'h00};
   dpll_phase_sync_config dpll_phase_sync_config_inst (
      .ref_clk_i, .rstn_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
      .reg_rd_i, .reg_rdata_o, .primary_phase_i, .secondary_phase_i,
      .phase_select_secondary_i, .sync_source_secondary_o,
      .frame_pulse_polarity_o, .frame_pulse_mode_o,
      .multiframe_pulse_polarity_o, .multiframe_pulse_mode_o,
      .sync_outputs_independent_o, .optical_rate_realign_o,
      .sync_sample_phase_o, .coarse_range_code_o, .coarse_loss_en_o,
      .wide_range_en_o, .applied_offset_o, .holdover_force_o,
      .divider_reset_o, .calibration_busy_o);
   // 50 MHz clock
   initial begin
      ref_clk_i = 1'b0;
      forever #10 ref_clk_i = ~ref_clk_i;
   end
   // ***************************************************************
   // access tasks, driven on the falling edge
   // ***************************************************************
   // one-cycle write strobe; an idle cycle follows each access
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge ref_clk_i);
      reg_addr_i  = a;
      reg_wdata_i = d;
      reg_wr_i    = 1'b1;
      @(negedge ref_clk_i);
      reg_wr_i = 1'b0;
   endtask
   // read strobe, data settled by the next falling edge
   task automatic expect_rd(input logic [7:0] a, input logic [7:0] e);
      @(negedge ref_clk_i);
      reg_addr_i = a;
      reg_rd_i   = 1'b1;
      @(negedge ref_clk_i);
      reg_rd_i = 1'b0;
      `CHK(reg_rdata_o, e)
   endtask
   task final_report;
      if (error_cnt == 0 && check_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // ***************************************************************
   // main sequence
   // ***************************************************************
   initial begin
      {rstn_i, reg_wr_i, reg_rd_i, phase_select_secondary_i} = 4'h0;
      {reg_addr_i, reg_wdata_i} = 16'h0000;
      primary_phase_i   = 16'h1234;
      secondary_phase_i = 16'hFEDC;
      error_cnt   = 0;
      check_count = 0;
      repeat (3) @(negedge ref_clk_i);
      rstn_i = 1'b1;
      // reset values and access kinds
      expect_rd(8'h74, 8'h85);
      `CHK({coarse_loss_en_o, wide_range_en_o, coarse_range_code_o}, 6'h25)
      expect_rd(8'h75, 8'h06);
      expect_rd(8'h7C, 8'h2B);
      expect_rd(8'h7A, 8'h00);
      expect_rd(8'h7B, 8'h00);
      wr(8'h79, 8'h00);
      expect_rd(8'h79, 8'h32);
      wr(8'h7F, 8'hFF);
      expect_rd(8'h7F, 8'h00);
      expect_rd(8'h00, 8'h00);
      // every tracking range code, saturating from 1100 up
      for (n = 0; n < 16; n++) begin
         wr(8'h74, 8'h40 | 8'(n));
         `CHK(coarse_range_code_o, (n > 12) ? 4'hC : 4'(n))
         `CHK({coarse_loss_en_o, wide_range_en_o}, 2'b01)
         expect_rd(8'h74, 8'h40 | 8'(n));
      end
      // each pulse control bit alone
      foreach (pat[i]) begin
         wr(8'h7A, pat[i]);
         `CHK({sync_source_secondary_o, frame_pulse_polarity_o, frame_pulse_mode_o, multiframe_pulse_polarity_o, multiframe_pulse_mode_o}, {pat[i][7], pat[i][3:0]})
         expect_rd(8'h7A, pat[i]);
      end
      // alignment options
      wr(8'h7B, 8'hC3);
      `CHK({sync_outputs_independent_o, optical_rate_realign_o, sync_sample_phase_o}, 4'hF)
      wr(8'h7B, 8'h42);
      `CHK({sync_outputs_independent_o, optical_rate_realign_o, sync_sample_phase_o}, 4'h6)
      expect_rd(8'h7B, 8'h42);
      // low byte read snapshots the high byte of the selected loop
      expect_rd(8'h77, 8'h34);
      primary_phase_i = 16'h5678;
      expect_rd(8'h78, 8'h12);
      phase_select_secondary_i = 1'b1;
      expect_rd(8'h77, 8'hDC);
      expect_rd(8'h78, 8'hFE);
      // offset write ramps one step at a time
      wr(8'h70, 8'h03);
      wr(8'h71, 8'h00);
      n = 0;
      while (applied_offset_o !== 16'h0003 && n < 400) begin
         @(negedge ref_clk_i);
         n++;
      end
      `CHK(n >= 90 && n < 400, 1'b1)
      if (n >= 400)
         final_report;
      // forced calibration: hold, zero, divider reset, back to target
      wr(8'h7C, 8'hAB);
      {n, dcnt, hcnt} = '0;
      while (n < 1500 && (hcnt == 0 || holdover_force_o !== 1'b0)) begin
         @(negedge ref_clk_i);
         n++;
         dcnt += (divider_reset_o === 1'b1);
         hcnt += (holdover_force_o === 1'b1);
      end
      `CHK(dcnt, 8)
      `CHK(applied_offset_o, 16'h0003)
      `CHK(n < 1500, 1'b1)
      `CHK(holdover_force_o, 1'b0)
      `CHK(calibration_busy_o, 1'b1)
      if (n >= 1500)
         final_report;
      wr(8'h7C, 8'h2B);
      @(negedge ref_clk_i);
      `CHK(calibration_busy_o, 1'b0)
      // second reset in mid-run
      rstn_i = 1'b0;
      repeat (2) @(negedge ref_clk_i);
      rstn_i = 1'b1;
      `CHK(applied_offset_o, 16'h0000)
      expect_rd(8'h74, 8'h85);
      expect_rd(8'h7A, 8'h00);
      final_report;
   end
endmodule
`default_nettype wire
